// File: src/emsd_consts.svh
// Constants for the external memory select decoder
`ifndef EMSD_CONSTS_SVH
`define EMSD_CONSTS_SVH

`define EMSD_ADDR_W 24
`define EMSD_EXT_ADDR_W 21
`define EMSD_CS0_RESET_BASE 24'hFF2000
`define EMSD_CS0_RESET_LIMIT 24'hFF20FF
`define EMSD_EMPTY_BASE 24'hFFFFFF
`define EMSD_EMPTY_LIMIT 24'h000000
`define EMSD_PART_BASE 24'hFF2000
`define EMSD_PART_LIMIT 24'hFF3FFF
`define EMSD_UPPER_LSB 16
`define EMSD_CS_PORT_LSB 5
`define EMSD_REGION_CNT 3
`define EMSD_DEFAULT_REGION 2

`endif

// File: src/emsd_pkg.sv
// Types for the external memory select decoder
package emsd_pkg;
    typedef logic [23:0] emsd_addr_t;
    typedef logic [7:0] emsd_bus_cfg_t;

    // One programmed address window with its bus configuration
    typedef struct packed {
        emsd_addr_t base;
        emsd_addr_t limit;
        emsd_bus_cfg_t cfg;
    } emsd_range_s;

    typedef struct packed {
        logic valid;
        emsd_addr_t addr;
    } emsd_req_s;

    typedef enum logic [1:0] {
        EMSD_IN_RESET = 2'b01,
        EMSD_RUN = 2'b10
    } emsd_state_e;
endpackage

// File: src/emsd_decode.sv
// External memory chip-select decoder with strap latch and extended port
// Notes on behaviour
// - A region's active-low select goes low during an external cycle whose address is in that region's range.
// - An external address matching no region leaves all selects high.
// - An unmatched external cycle uses region 2's bus configuration.
// - After reset region 0 covers FF2000-FF20FF, seen externally as 1F2000-1F20FF.
// - Partition FF2000-FF3FFF goes internal if the strap was latched high, external if low.
// - Accesses outside that partition are routed regardless of the strap.
// - The strap is sampled only at reset release; later changes have no effect.
// - Extended port bits 4:0 carry address bits 20:16 and bits 7:5 carry the three selects.
`timescale 1ns/1ps
`default_nettype none
`include "emsd_consts.svh"

module emsd_decode
    import emsd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic external_access_strap_n_i,
    input wire emsd_req_s req_i,
    input wire logic prog_we_i,
    input wire logic [1:0] prog_region_i,
    input wire emsd_range_s prog_range_i,
    output logic ext_cycle_o,
    output logic int_cycle_o,
    output logic [20:0] ext_addr_o,
    output logic [2:0] region_select_n_o,
    output emsd_bus_cfg_t bus_cfg_o,
    output logic [7:0] extended_address_port_o,
    output logic strap_high_o
);

    function automatic logic in_range(input emsd_addr_t a, input emsd_addr_t lo, input emsd_addr_t hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    emsd_range_s range_q [`EMSD_REGION_CNT];
    emsd_state_e state_q;
    logic strap_q;
    logic [2:0] hit;
    logic to_ext;
    emsd_bus_cfg_t cfg_d;

    // ----------------------------------------
    // Reset tracking and strap latch
    // ----------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_q <= EMSD_IN_RESET;
        end else begin
            state_q <= EMSD_RUN;
        end
    end

    // Caught on the first clock after release so a late strap glitch cannot reroute
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            strap_q <= 1'b0;
        end else if (state_q == EMSD_IN_RESET) begin
            strap_q <= external_access_strap_n_i;
        end
    end

    // ----------------------------------------
    // Range registers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `EMSD_REGION_CNT; g++) begin : g_rng
            always_ff @(posedge clk_sys_i) begin
                if (sys_rst_i) begin
                    if (g == 0) begin
                        range_q[g] <= '{`EMSD_CS0_RESET_BASE, `EMSD_CS0_RESET_LIMIT, 8'h00};
                    end else begin
                        // Empty window: base above limit never matches
                        range_q[g] <= '{`EMSD_EMPTY_BASE, `EMSD_EMPTY_LIMIT, 8'h00};
                    end
                end else if (prog_we_i && prog_region_i == 2'(g)) begin
                    range_q[g] <= prog_range_i;
                end
            end
            assign hit[g] = in_range(req_i.addr, range_q[g].base, range_q[g].limit);
        end
    endgenerate

    // ----------------------------------------
    // Routing and decode
    // ----------------------------------------
    always_comb begin
        // Strap only matters inside the partition
        if (in_range(req_i.addr, `EMSD_PART_BASE, `EMSD_PART_LIMIT)) begin
            to_ext = ~strap_q;
        end else begin
            to_ext = 1'b1;
        end
        if (hit[0]) begin
            cfg_d = range_q[0].cfg;
        end else if (hit[1]) begin
            cfg_d = range_q[1].cfg;
        end else if (hit[2]) begin
            cfg_d = range_q[2].cfg;
        end else begin
            cfg_d = range_q[`EMSD_DEFAULT_REGION].cfg;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ext_cycle_o <= 1'b0;
            int_cycle_o <= 1'b0;
            ext_addr_o <= 21'h0;
            region_select_n_o <= 3'h7;
            bus_cfg_o <= 8'h00;
            extended_address_port_o <= 8'hE0;
            strap_high_o <= 1'b0;
        end else begin
            strap_high_o <= strap_q;
            ext_cycle_o <= req_i.valid && to_ext;
            int_cycle_o <= req_i.valid && !to_ext;
            if (req_i.valid && to_ext) begin
                ext_addr_o <= req_i.addr[20:0];
                region_select_n_o <= ~hit;
                bus_cfg_o <= cfg_d;
                extended_address_port_o <= {~hit, req_i.addr[20:16]};
            end else begin
                region_select_n_o <= 3'h7;
                extended_address_port_o <= {3'h7, ext_addr_o[20:16]};
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_sel;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_i.valid && to_ext && hit[0]) |=> !region_select_n_o[0];
    endproperty
    a_sel: assert property (p_sel) else $error("region 0 select not asserted");

    property p_nosel;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (hit == 3'h0) |=> (region_select_n_o == 3'h7);
    endproperty
    a_nosel: assert property (p_nosel) else $error("select asserted with no match");

    property p_dflt;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_i.valid && to_ext && hit == 3'h0) |=> (bus_cfg_o == $past(range_q[2].cfg));
    endproperty
    a_dflt: assert property (p_dflt) else $error("default config not region 2");

    property p_part;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_i.valid && in_range(req_i.addr, `EMSD_PART_BASE, `EMSD_PART_LIMIT)) |=> (int_cycle_o == strap_high_o);
    endproperty
    a_part: assert property (p_part) else $error("partition routed against strap");

    property p_out;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_i.valid && !in_range(req_i.addr, `EMSD_PART_BASE, `EMSD_PART_LIMIT)) |=> ext_cycle_o;
    endproperty
    a_out: assert property (p_out) else $error("non-partition access not external");

    property p_strap;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_q == EMSD_RUN) |=> $stable(strap_q);
    endproperty
    a_strap: assert property (p_strap) else $error("strap changed after reset");

    property p_port;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        ext_cycle_o |-> (extended_address_port_o == {region_select_n_o, ext_addr_o[20:16]});
    endproperty
    a_port: assert property (p_port) else $error("extended port mismatch");

    property p_addr;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_i.valid && to_ext) |=> (ext_addr_o == $past(req_i.addr[20:0]));
    endproperty
    a_addr: assert property (p_addr) else $error("external address wrong");

    property p_sel1;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_i.valid && to_ext && hit[1]) |=> !region_select_n_o[1];
    endproperty
    a_sel1: assert property (p_sel1) else $error("region 1 select not asserted");

    property p_sel2;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_i.valid && to_ext && hit[2]) |=> !region_select_n_o[2];
    endproperty
    a_sel2: assert property (p_sel2) else $error("region 2 select not asserted");

    // Overlapping windows all assert their selects, so compare the whole vector
    property p_sel_exact;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (req_i.valid && to_ext) |=> (region_select_n_o == ~$past(hit));
    endproperty
    a_sel_exact: assert property (p_sel_exact) else $error("select vector differs from match");

    property p_int_quiet;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        int_cycle_o |-> (region_select_n_o == 3'h7);
    endproperty
    a_int_quiet: assert property (p_int_quiet) else $error("select asserted on internal access");

    property p_idle;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !req_i.valid |=> (!ext_cycle_o && !int_cycle_o && region_select_n_o == 3'h7);
    endproperty
    a_idle: assert property (p_idle) else $error("bus activity without request");

    // Checked across reset itself, so no disable here
    property p_rst_window;
        @(posedge clk_sys_i)
        sys_rst_i |=> (range_q[0].base == `EMSD_CS0_RESET_BASE && range_q[0].limit == `EMSD_CS0_RESET_LIMIT);
    endproperty
    a_rst_window: assert property (p_rst_window) else $error("region 0 power-up window wrong");

    property p_strap_take;
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (state_q == EMSD_IN_RESET) |=> (strap_q == $past(external_access_strap_n_i));
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("strap not taken at reset release");

endmodule // emsd_decode
`default_nettype wire

// File: test/emsd_mem_model.sv
// Behavioural external memory that counts the cycles in which it is selected
`timescale 1ns/1ps
`default_nettype none
module emsd_mem_model (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [2:0] region_select_n_i,
    output logic [15:0] sel_cycles_o
);
    // Any low select enables a device for that cycle
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sel_cycles_o <= 16'h0;
        end else if (region_select_n_i != 3'h7) begin
            sel_cycles_o <= sel_cycles_o + 16'h1;
        end
    end
endmodule // emsd_mem_model
`default_nettype wire

// File: test/external_memory_select_decode_tb.sv
// Self-checking bench for the external memory select decoder
`timescale 1ns/1ps
`default_nettype none
module external_memory_select_decode_tb;
    import emsd_pkg::*;
    logic clk_sys_i = 0, sys_rst_i = 1, strap_n = 1, prog_we = 0, ext_c, int_c, strap_h;
    logic [1:0] prog_region = 0;
    emsd_req_s req = '0;
    emsd_range_s prog_range = '0;
    logic [20:0] ext_a, m_last;
    logic [2:0] sel_n;
    logic [7:0] port;
    logic [15:0] mem_sel, m_selcnt;
    emsd_bus_cfg_t cfg;
    emsd_addr_t m_base [3], m_limit [3], b, a;
    emsd_bus_cfg_t m_cfg [3];
    logic m_strap;
    int miscompares = 0, n_compared = 0, cycles = 0;
    emsd_decode dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .external_access_strap_n_i(strap_n),
        .req_i(req), .prog_we_i(prog_we), .prog_region_i(prog_region), .prog_range_i(prog_range),
        .ext_cycle_o(ext_c), .int_cycle_o(int_c), .ext_addr_o(ext_a), .region_select_n_o(sel_n),
        .bus_cfg_o(cfg), .extended_address_port_o(port), .strap_high_o(strap_h));
    emsd_mem_model mem (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .region_select_n_i(sel_n),
        .sel_cycles_o(mem_sel));
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    // ----------------------------------------
    // Checking tasks
    // ----------------------------------------
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (exp !== got) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles > 4000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic do_reset(logic s);
        sys_rst_i = 1;
        strap_n = s;
        repeat (12) @(negedge clk_sys_i);
        chk("port_rst", 8'hE0, port);
        chk("select_rst", 3'h7, sel_n);
        sys_rst_i = 0;
        m_base = '{24'hFF2000, 24'hFFFFFF, 24'hFFFFFF};
        m_limit = '{24'hFF20FF, 24'h0, 24'h0};
        m_cfg = '{8'h0, 8'h0, 8'h0};
        m_strap = s;
        m_last = '0;
        m_selcnt = '0;
        repeat (2) @(negedge clk_sys_i);
        chk("strap", s, strap_h);
    endtask
    task automatic prog(logic [1:0] r, emsd_addr_t pb, emsd_addr_t pl, emsd_bus_cfg_t pc);
        prog_we = 1;
        prog_region = r;
        prog_range = '{pb, pl, pc};
        @(negedge clk_sys_i);
        prog_we = 0;
        if (r != 2'h3) begin
            m_base[r] = pb;
            m_limit[r] = pl;
            m_cfg[r] = pc;
        end
        // Let an edge pass so a following call never re-raises the strobe in this step
        @(negedge clk_sys_i);
    endtask
    // Back-to-back: valid stays high until the caller clears req.valid
    task automatic access(emsd_addr_t x);
        logic [2:0] s;
        logic ext;
        emsd_bus_cfg_t c;
        s = 3'h7;
        c = m_cfg[2];
        ext = !(m_strap && x >= 24'hFF2000 && x <= 24'hFF3FFF);
        for (int r = 2; r >= 0; r--) if (x >= m_base[r] && x <= m_limit[r]) begin
            s[r] = 1'b0;
            c = m_cfg[r];
        end
        if (!ext) s = 3'h7;
        req = '{1'b1, x};
        @(negedge clk_sys_i);
        chk("ext_cycle", ext, ext_c);
        chk("int_cycle", !ext, int_c);
        chk("select_n", s, sel_n);
        if (ext) begin
            m_last = x[20:0];
            if (s != 3'h7) m_selcnt++;
            chk("bus_cfg", c, cfg);
            chk("ext_addr", x[20:0], ext_a);
        end
        chk("port", {s, m_last[20:16]}, port);
    endtask
    task automatic run_fixed();
        emsd_addr_t t [7] = '{24'hFF2000, 24'hFF20FF, 24'hFF1FFF, 24'hFF2100, 24'hFF3FFF, 24'hFF4000, 24'h012345};
        foreach (t[i]) access(t[i]);
        req.valid = 0;
        repeat (2) @(negedge clk_sys_i);
    endtask
    initial begin
        void'($urandom(74));
        do_reset(1'b1);
        run_fixed();
        strap_n = 0;
        run_fixed();
        chk("strap_hold", 1'b1, strap_h);
        do_reset(1'b0);
        run_fixed();
        b = 24'($urandom_range(24'h0FFF00, 24'h001000)) & 24'hFFFF00;
        prog(2'h1, b, b + 24'hFF, 8'($urandom));
        prog(2'h2, b + 24'h80, b + 24'h17F, 8'($urandom));
        prog(2'h3, 24'h0, 24'hFFFFFF, 8'hA5);
        repeat (60) begin
            case ($urandom_range(2, 0))
                0: a = b + 24'($urandom_range(24'h1BF, 0));
                1: a = 24'hFF2000 + 24'($urandom_range(24'h1FF, 0));
                default: a = 24'($urandom);
            endcase
            access(a);
        end
        req.valid = 0;
        repeat (3) @(negedge clk_sys_i);
        chk("mem_sel_cycles", m_selcnt, mem_sel);
        report_and_stop();
    end
endmodule // external_memory_select_decode_tb
`default_nettype wire
